// ---- logic/uart_ctrl_pkg.sv ----
/*
  Constants and types for the serial port register control block.
  Assumes a host register port with 3-bit offset, one system clock.
*/
// Notes on behaviour
// RULE_01: enable bit 0 gates received-data and, in FIFO mode, timeout interrupts.
// RULE_02: enable bit 1 gates the transmit-holding-empty interrupt.
// RULE_03: enable bit 2 gates line-status interrupt from overrun, parity, framing, break.
// RULE_04: reading line status tells the error and clears the line-status interrupt.
// RULE_05: enable bit 3 gates modem-status interrupt raised on any modem bit change.
// RULE_06: enable bits 4 to 7 always read zero.
// RULE_07: FIFO control is write-only at offset 2, where identification is read.
// RULE_08: FIFO bit 0 enables both FIFOs; zero disables and flushes them.
// RULE_09: software writes FIFO bit 0 as one with any other FIFO bits.
// RULE_10: FIFO bit 1 flushes receive FIFO, keeps shift register, self-clears.
// RULE_11: FIFO bit 2 flushes transmit FIFO, keeps shift register, self-clears.
// RULE_12: FIFO bit 3 writes are ignored; no ready pins exist.
// RULE_13: FIFO bits 7:6 pick receive trigger level 1, 4, 8 or 14.
// RULE_14: priority line status, received data or timeout, transmit empty, modem.
// RULE_15: identification is frozen while host accesses it; new events wait.
// RULE_16: identification bit 0 is zero when an enabled interrupt is pending.
// RULE_17: identification bits 2:1 code source 11, 10, 01, 00.
// RULE_18: identification bit 3 marks timeout in FIFO mode, zero otherwise.
// RULE_19: identification bits 7:6 follow FIFO enable; bits 5:4 read zero.
// RULE_20: line control bits 1:0 pick 5, 6, 7 or 8 data bits.
// RULE_21: line control bit 2 gives 1 stop, or 1.5 for 5-bit, else 2.
// RULE_22: receiver checks only the first stop bit.
// RULE_23: line control bit 7 steers offsets 0 and 1 to divisor latches.
// RULE_24: data interrupt clears on buffer read or below trigger; timeout on read.
// RULE_25: transmit empty clears on identification read as source or buffer write.
package uart_ctrl_pkg;
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_ENABLE = 3'h1;
  localparam logic [2:0] OFS_IDENT = 3'h2;
  localparam logic [2:0] OFS_LINE = 3'h3;
  localparam logic [2:0] OFS_LSTAT = 3'h5;
  localparam logic [2:0] OFS_MSTAT = 3'h6;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] LINE_RESET = 8'h00;
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam int EN_RX = 0;
  localparam int EN_TX = 1;
  localparam int EN_LS = 2;
  localparam int EN_MS = 3;
  localparam int FC_EN = 0;
  localparam int FC_RXCLR = 1;
  localparam int FC_TXCLR = 2;
  localparam int LC_STOP = 2;
  localparam int LC_DIV = 7;
  localparam logic [4:0] TRIG_1 = 5'h01;
  localparam logic [4:0] TRIG_4 = 5'h04;
  localparam logic [4:0] TRIG_8 = 5'h08;
  localparam logic [4:0] TRIG_14 = 5'h0E;
  localparam logic [2:0] ID_NONE = 3'h1;
  localparam logic [2:0] ID_LS = 3'h6;
  localparam logic [2:0] ID_RX = 3'h4;
  localparam logic [2:0] ID_TX = 3'h2;
  localparam logic [2:0] ID_MS = 3'h0;
  localparam logic [1:0] ID_FIFO_ON = 2'h3;
  typedef enum logic [2:0] {
    HOST_IDLE = 3'b001,
    HOST_BUSY = 3'b010,
    HOST_DONE = 3'b100
  } host_state_type;
  typedef struct packed {
    logic line_err;
    logic rx_avail;
    logic rx_timeout;
    logic tx_empty_edge;
    logic modem_change;
  } irq_src_type;
  typedef struct packed {
    logic [3:0] data_bits;
    logic [1:0] stop_halves;
  } frame_type;
endpackage : uart_ctrl_pkg

// ---- logic/uart_irq_fifo_line_ctrl.sv ----
/*
  Interrupt enable, FIFO control, interrupt identification and line control
  of a serial port. Assumes the receiver, transmitter and FIFOs sit outside
  on CORE_CLK; bus strobes are one-cycle synchronous pulses on CORE_CLK.
*/
module uart_irq_fifo_line_ctrl (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic CLK_EN,
  // host register port
  input wire logic [2:0] ADDR,
  input wire logic WR_STB,
  input wire logic RD_STB,
  input wire logic [7:0] WDATA,
  output logic [7:0] RDATA,
  // event sources from the datapath
  input wire logic [4:0] LINE_ERR_IN,
  input wire logic RX_LEVEL_MET,
  input wire logic [4:0] RX_COUNT,
  input wire logic RX_TIMEOUT_IN,
  input wire logic TX_EMPTY_IN,
  input wire logic MODEM_CHANGE_IN,
  // datapath controls
  output logic FIFO_ENABLE,
  output logic RX_FLUSH,
  output logic TX_FLUSH,
  output logic [4:0] RX_TRIGGER,
  output logic [1:0] WORD_LEN,
  output logic [3:0] DATA_BITS,
  output logic [1:0] STOP_HALVES,
  output logic STOP_CHECK_ONE,
  output logic DIVISOR_ACCESS,
  output logic [15:0] DIVISOR,
  output logic IRQ_PENDING
);
  function automatic logic [4:0] trigger_of(input logic [1:0] sel);
    case (sel)
      2'h0: trigger_of = uart_ctrl_pkg::TRIG_1;
      2'h1: trigger_of = uart_ctrl_pkg::TRIG_4;
      2'h2: trigger_of = uart_ctrl_pkg::TRIG_8;
      default: trigger_of = uart_ctrl_pkg::TRIG_14;
    endcase
  endfunction : trigger_of

  // inputs from the datapath share CORE_CLK and need no synchroniser
  logic [7:0] enable_reg, enable_next;
  logic [7:0] line_reg, line_next;
  logic [15:0] div_reg, div_next;
  logic fifo_en_reg, fifo_en_next;
  logic [1:0] trig_sel_reg, trig_sel_next;
  logic rx_flush_reg, rx_flush_next;
  logic tx_flush_reg, tx_flush_next;
  // trigger level is registered so the datapath never sees a decode glitch
  logic [4:0] trig_reg, trig_next;
  logic stop_one_reg;
  logic ls_pend_reg, ls_pend_next;
  logic ms_pend_reg, ms_pend_next;
  logic tx_pend_reg, tx_pend_next;
  logic tx_empty_prev_reg, tx_empty_prev_next;
  logic [2:0] ident_reg, ident_next;
  logic timeout_flag_reg, timeout_flag_next;
  logic [7:0] rdata_reg, rdata_next;
  logic irq_reg, irq_next;
  uart_ctrl_pkg::host_state_type host_reg, host_next;
  uart_ctrl_pkg::irq_src_type src;
  logic wr_data, wr_enable, wr_ident, wr_line, rd_data, rd_ident, rd_lstat, rd_mstat;
  logic rx_pend, to_pend, tx_act, ms_act, ls_act;
  logic [2:0] live_id;

  always_comb begin
    wr_data = WR_STB && ADDR == uart_ctrl_pkg::OFS_DATA && !line_reg[uart_ctrl_pkg::LC_DIV];
    wr_enable = WR_STB && ADDR == uart_ctrl_pkg::OFS_ENABLE && !line_reg[uart_ctrl_pkg::LC_DIV];
    wr_ident = WR_STB && ADDR == uart_ctrl_pkg::OFS_IDENT; // RULE_07
    wr_line = WR_STB && ADDR == uart_ctrl_pkg::OFS_LINE;
    rd_data = RD_STB && ADDR == uart_ctrl_pkg::OFS_DATA && !line_reg[uart_ctrl_pkg::LC_DIV];
    rd_ident = RD_STB && ADDR == uart_ctrl_pkg::OFS_IDENT;
    rd_lstat = RD_STB && ADDR == uart_ctrl_pkg::OFS_LSTAT;
    rd_mstat = RD_STB && ADDR == uart_ctrl_pkg::OFS_MSTAT;
  end

  // register writes and FIFO control
  always_comb begin
    enable_next = enable_reg;
    line_next = line_reg;
    div_next = div_reg;
    fifo_en_next = fifo_en_reg;
    trig_sel_next = trig_sel_reg;
    rx_flush_next = 1'b0; // RULE_10
    tx_flush_next = 1'b0; // RULE_11
    if (wr_enable) begin
      enable_next = {4'h0, WDATA[3:0]}; // RULE_06
    end
    if (wr_line) begin
      line_next = WDATA; // RULE_20
    end
    if (WR_STB && line_reg[uart_ctrl_pkg::LC_DIV]) begin
      if (ADDR == uart_ctrl_pkg::OFS_DATA) begin
        div_next[7:0] = WDATA; // RULE_23
      end else if (ADDR == uart_ctrl_pkg::OFS_ENABLE) begin
        div_next[15:8] = WDATA; // RULE_23
      end
    end
    if (wr_ident) begin
      fifo_en_next = WDATA[uart_ctrl_pkg::FC_EN]; // RULE_08
      // other bits only take when enable is written as one; bit 3 is dropped
      if (WDATA[uart_ctrl_pkg::FC_EN]) begin // RULE_09 RULE_12
        trig_sel_next = WDATA[7:6]; // RULE_13
        rx_flush_next = WDATA[uart_ctrl_pkg::FC_RXCLR]; // RULE_10
        tx_flush_next = WDATA[uart_ctrl_pkg::FC_TXCLR]; // RULE_11
      end
      if (fifo_en_reg != WDATA[uart_ctrl_pkg::FC_EN]) begin
        rx_flush_next = 1'b1; // RULE_08
        tx_flush_next = 1'b1; // RULE_08
      end
    end
    trig_next = trigger_of(trig_sel_next); // RULE_13
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      enable_reg <= uart_ctrl_pkg::ENABLE_RESET;
      line_reg <= uart_ctrl_pkg::LINE_RESET;
      div_reg <= {uart_ctrl_pkg::DIV_RESET, uart_ctrl_pkg::DIV_RESET};
      fifo_en_reg <= 1'b0;
      trig_sel_reg <= 2'h0;
      trig_reg <= uart_ctrl_pkg::TRIG_1;
      rx_flush_reg <= 1'b0;
      tx_flush_reg <= 1'b0;
    end else if (CLK_EN) begin
      enable_reg <= enable_next;
      line_reg <= line_next;
      div_reg <= div_next;
      fifo_en_reg <= fifo_en_next;
      trig_sel_reg <= trig_sel_next;
      trig_reg <= trig_next;
      rx_flush_reg <= rx_flush_next;
      tx_flush_reg <= tx_flush_next;
    end
  end

  // interrupt sources and priority
  always_comb begin
    src.line_err = |LINE_ERR_IN;
    src.rx_avail = RX_LEVEL_MET;
    // a timeout only means something while bytes wait in the receive fifo
    src.rx_timeout = RX_TIMEOUT_IN && fifo_en_reg && RX_COUNT != 5'h00; // RULE_18
    src.tx_empty_edge = TX_EMPTY_IN && !tx_empty_prev_reg;
    src.modem_change = MODEM_CHANGE_IN;
    // a new event in the clearing cycle wins over the clear
    ls_pend_next = src.line_err || (ls_pend_reg && !rd_lstat); // RULE_03 RULE_04
    ms_pend_next = src.modem_change || (ms_pend_reg && !rd_mstat); // RULE_05
    tx_pend_next = src.tx_empty_edge ||
      (tx_pend_reg && !wr_data && !(rd_ident && ident_reg == uart_ctrl_pkg::ID_TX)); // RULE_25
    tx_empty_prev_next = TX_EMPTY_IN;
    // data level falls with the FIFO; timeout clears on buffer read
    rx_pend = src.rx_avail && !rd_data; // RULE_24
    to_pend = src.rx_timeout && !rd_data; // RULE_24
    ls_act = ls_pend_reg && enable_reg[uart_ctrl_pkg::EN_LS]; // RULE_03
    tx_act = tx_pend_reg && enable_reg[uart_ctrl_pkg::EN_TX]; // RULE_02
    ms_act = ms_pend_reg && enable_reg[uart_ctrl_pkg::EN_MS]; // RULE_05
    rx_pend = rx_pend && enable_reg[uart_ctrl_pkg::EN_RX]; // RULE_01
    to_pend = to_pend && enable_reg[uart_ctrl_pkg::EN_RX]; // RULE_01
    if (ls_act) begin // RULE_14
      live_id = uart_ctrl_pkg::ID_LS; // RULE_17
    end else if (rx_pend || to_pend) begin
      live_id = uart_ctrl_pkg::ID_RX;
    end else if (tx_act) begin
      live_id = uart_ctrl_pkg::ID_TX;
    end else if (ms_act) begin
      live_id = uart_ctrl_pkg::ID_MS;
    end else begin
      live_id = uart_ctrl_pkg::ID_NONE; // RULE_16
    end
    // hold the shown code while the host is reading it
    host_next = host_reg;
    ident_next = live_id;
    timeout_flag_next = to_pend && !ls_act && !rx_pend; // RULE_18
    case (host_reg)
      uart_ctrl_pkg::HOST_IDLE: begin
        if (rd_ident) begin
          host_next = uart_ctrl_pkg::HOST_BUSY;
        end
      end
      uart_ctrl_pkg::HOST_BUSY: begin
        host_next = uart_ctrl_pkg::HOST_DONE;
      end
      uart_ctrl_pkg::HOST_DONE: begin
        // a back-to-back read starts a fresh access window
        if (rd_ident) begin
          host_next = uart_ctrl_pkg::HOST_BUSY;
        end else begin
          host_next = uart_ctrl_pkg::HOST_IDLE;
        end
      end
      default: host_next = uart_ctrl_pkg::HOST_IDLE;
    endcase
    if (rd_ident || host_reg == uart_ctrl_pkg::HOST_BUSY) begin
      ident_next = ident_reg; // RULE_15
      timeout_flag_next = timeout_flag_reg; // RULE_15
    end
    irq_next = ident_next != uart_ctrl_pkg::ID_NONE;
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      ls_pend_reg <= 1'b0;
      ms_pend_reg <= 1'b0;
      tx_pend_reg <= 1'b0;
      tx_empty_prev_reg <= 1'b0;
      ident_reg <= uart_ctrl_pkg::ID_NONE;
      timeout_flag_reg <= 1'b0;
      host_reg <= uart_ctrl_pkg::HOST_IDLE;
      irq_reg <= 1'b0;
    end else if (CLK_EN) begin
      ls_pend_reg <= ls_pend_next;
      ms_pend_reg <= ms_pend_next;
      tx_pend_reg <= tx_pend_next;
      tx_empty_prev_reg <= tx_empty_prev_next;
      ident_reg <= ident_next;
      timeout_flag_reg <= timeout_flag_next;
      host_reg <= host_next;
      irq_reg <= irq_next;
    end
  end

  // read data, registered one cycle after the strobe
  always_comb begin
    rdata_next = rdata_reg;
    if (RD_STB) begin
      case (ADDR)
        uart_ctrl_pkg::OFS_DATA: begin
          rdata_next = line_reg[uart_ctrl_pkg::LC_DIV] ? div_reg[7:0] : 8'h00;
        end
        uart_ctrl_pkg::OFS_ENABLE: begin
          rdata_next = line_reg[uart_ctrl_pkg::LC_DIV] ? div_reg[15:8] :
            {4'h0, enable_reg[3:0]}; // RULE_06 RULE_23
        end
        uart_ctrl_pkg::OFS_IDENT: begin
          rdata_next = {fifo_en_reg ? uart_ctrl_pkg::ID_FIFO_ON : 2'h0, 2'h0,
            timeout_flag_reg && fifo_en_reg, ident_reg}; // RULE_18 RULE_19 RULE_16
        end
        uart_ctrl_pkg::OFS_LINE: rdata_next = line_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      rdata_reg <= 8'h00;
    end else if (CLK_EN) begin
      rdata_reg <= rdata_next;
    end
  end

  // frame format decode; receiver checks one stop bit whatever is set
  // decoded from the next line value so the format lands with the write
  uart_ctrl_pkg::frame_type frame;
  always_comb begin
    frame.data_bits = 4'h5 + {2'h0, line_next[1:0]}; // RULE_20
    if (!line_next[uart_ctrl_pkg::LC_STOP]) begin
      frame.stop_halves = 2'h2; // RULE_21
    end else if (line_next[1:0] == 2'h0) begin
      frame.stop_halves = 2'h3; // RULE_21
    end else begin
      frame.stop_halves = 2'h0; // RULE_21 (2'h0 codes four halves)
    end
  end

  logic [3:0] bits_reg;
  logic [1:0] halves_reg;
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      bits_reg <= 4'h5;
      halves_reg <= 2'h2;
      stop_one_reg <= 1'b1;
    end else if (CLK_EN) begin
      bits_reg <= frame.data_bits;
      halves_reg <= frame.stop_halves;
      // kept in a flop so every output leaves a register
      stop_one_reg <= 1'b1; // RULE_22
    end
  end

  assign RDATA = rdata_reg;
  assign FIFO_ENABLE = fifo_en_reg;
  assign RX_FLUSH = rx_flush_reg;
  assign TX_FLUSH = tx_flush_reg;
  assign RX_TRIGGER = trig_reg; // RULE_13
  assign WORD_LEN = line_reg[1:0];
  assign DATA_BITS = bits_reg;
  assign STOP_HALVES = halves_reg;
  assign STOP_CHECK_ONE = stop_one_reg; // RULE_22
  assign DIVISOR_ACCESS = line_reg[uart_ctrl_pkg::LC_DIV]; // RULE_23
  assign DIVISOR = div_reg;
  assign IRQ_PENDING = irq_reg;
endmodule : uart_irq_fifo_line_ctrl

// ---- bench/uart_ctrl_props.sv ----
/*
  Checker for the serial port control block.
  Bound to every instance of the block; sees its ports only.
*/
module uart_ctrl_props (
  // watched ports
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic CLK_EN,
  input wire logic [2:0] ADDR,
  input wire logic WR_STB,
  input wire logic RD_STB,
  input wire logic [7:0] WDATA,
  input wire logic [7:0] RDATA,
  input wire logic FIFO_ENABLE,
  input wire logic RX_FLUSH,
  input wire logic TX_FLUSH,
  input wire logic [4:0] RX_TRIGGER,
  input wire logic [1:0] WORD_LEN,
  input wire logic [3:0] DATA_BITS,
  input wire logic [1:0] STOP_HALVES,
  input wire logic STOP_CHECK_ONE,
  input wire logic DIVISOR_ACCESS
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!NRST);
  logic wr;
  logic rd;
  assign wr = WR_STB && CLK_EN;
  assign rd = RD_STB && CLK_EN;
  AST_DATA_LEN: assert property (DATA_BITS == {2'h0, WORD_LEN} + 4'h5)
    else $error("data bits do not follow word length");
  AST_STOP: assert property (wr && ADDR == 3'h3 |=> STOP_HALVES == (!$past(WDATA[2]) ? 2'h2 :
    ($past(WDATA[1:0]) == 2'h0 ? 2'h3 : 2'h0))) else $error("stop halves wrong");
  AST_STOP_ONE: assert property (STOP_CHECK_ONE)
    else $error("receiver checks more than one stop bit");
  AST_DIV_SEL: assert property (wr && ADDR == 3'h3 |=> DIVISOR_ACCESS == $past(WDATA[7]))
    else $error("divisor access does not follow line bit 7");
  AST_FIFO_EN: assert property (wr && ADDR == 3'h2 |=> FIFO_ENABLE == $past(WDATA[0]))
    else $error("fifo enable does not follow bit 0");
  AST_RX_FLUSH: assert property (wr && ADDR == 3'h2 && WDATA[1:0] == 2'h3 |=> RX_FLUSH)
    else $error("receive flush missing");
  AST_TX_FLUSH: assert property (wr && ADDR == 3'h2 && WDATA[2] && WDATA[0] |=> TX_FLUSH)
    else $error("transmit flush missing");
  AST_BIT3: assert property (wr && ADDR == 3'h2 && WDATA == 8'h09 && FIFO_ENABLE
    |=> !RX_FLUSH && !TX_FLUSH) else $error("bit 3 write had an effect");
  AST_TRIG: assert property (wr && ADDR == 3'h2 && WDATA[0] |=> RX_TRIGGER ==
    ($past(WDATA[7:6]) == 2'h0 ? 5'h01 : $past(WDATA[7:6]) == 2'h1 ? 5'h04 :
    $past(WDATA[7:6]) == 2'h2 ? 5'h08 : 5'h0E)) else $error("trigger level wrong");
  AST_IDENT_HIGH: assert property (rd && ADDR == 3'h2 |=> RDATA[5:4] == 2'h0 &&
    RDATA[7:6] == {2{$past(FIFO_ENABLE)}}) else $error("ident upper bits wrong");
  AST_ENABLE_TOP: assert property (rd && ADDR == 3'h1 && !DIVISOR_ACCESS |=> RDATA[7:4] == 4'h0)
    else $error("enable upper bits not zero");
  cover property (rd && ADDR == 3'h2 && FIFO_ENABLE);
  cover property (RX_FLUSH);
  cover property (wr && ADDR == 3'h3 && WDATA[7]);
endmodule : uart_ctrl_props

bind uart_irq_fifo_line_ctrl uart_ctrl_props i_uart_ctrl_props (.CORE_CLK(CORE_CLK),
  .NRST(NRST), .CLK_EN(CLK_EN), .ADDR(ADDR), .WR_STB(WR_STB), .RD_STB(RD_STB),
  .WDATA(WDATA), .RDATA(RDATA), .FIFO_ENABLE(FIFO_ENABLE), .RX_FLUSH(RX_FLUSH),
  .TX_FLUSH(TX_FLUSH), .RX_TRIGGER(RX_TRIGGER), .WORD_LEN(WORD_LEN), .DATA_BITS(DATA_BITS),
  .STOP_HALVES(STOP_HALVES), .STOP_CHECK_ONE(STOP_CHECK_ONE), .DIVISOR_ACCESS(DIVISOR_ACCESS));

// ---- bench/datapath_model.sv ----
/*
  Far-side datapath stand-in: event sources and receive fill level.
  Driven by the bench through its tasks on the shared clock.
*/
module datapath_model (
  // clock and controls from the block
  input wire logic clk,
  input wire logic rx_flush,
  input wire logic tx_flush,
  input wire logic [4:0] trigger,
  // event sources into the block
  output logic [4:0] line_err,
  output logic rx_level,
  output logic [4:0] rx_bytes,
  output logic rx_timeout,
  output logic tx_empty,
  output logic modem_change
);
  logic idle_long;
  initial begin
    line_err = 5'h00;
    rx_bytes = 5'h00;
    idle_long = 1'b0;
    tx_empty = 1'b0;
    modem_change = 1'b0;
  end
  assign rx_level = rx_bytes >= trigger;
  // a timeout only counts while data waits in the receive fifo
  assign rx_timeout = idle_long && rx_bytes != 5'h00;
  always @(posedge clk) begin
    if (rx_flush) rx_bytes <= 5'h00;
    if (tx_flush) tx_empty <= 1'b1;
  end
  task automatic pulse_err(input int b);
    @(posedge clk);
    line_err <= 5'h01 << b;
    @(posedge clk);
    line_err <= 5'h00;
  endtask : pulse_err
  task automatic pulse_modem;
    @(posedge clk);
    modem_change <= 1'b1;
    @(posedge clk);
    modem_change <= 1'b0;
  endtask : pulse_modem
  task automatic set_rx(input logic [4:0] n, input logic stale);
    @(posedge clk);
    rx_bytes <= n;
    idle_long <= stale;
  endtask : set_rx
  task automatic set_tx(input logic v);
    @(posedge clk);
    tx_empty <= v;
  endtask : set_tx
endmodule : datapath_model

// ---- bench/uart_irq_fifo_line_ctrl_tb_top.sv ----
/*
  Self-checking bench for the serial port control block.
  Host side is driven here; the datapath model stands at the far side.
*/
module uart_irq_fifo_line_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic CORE_CLK = 1'b0;
  logic NRST = 1'b0;
  logic [2:0] ADDR = 3'h0;
  logic WR_STB = 1'b0;
  logic RD_STB = 1'b0;
  logic CLK_EN = 1'b1;
  logic [7:0] WDATA = 8'h00;
  logic [7:0] RDATA;
  logic [4:0] LINE_ERR_IN, RX_COUNT, RX_TRIGGER;
  logic RX_LEVEL_MET, RX_TIMEOUT_IN, TX_EMPTY_IN, MODEM_CHANGE_IN, FIFO_ENABLE;
  logic RX_FLUSH, TX_FLUSH, DIVISOR_ACCESS, IRQ_PENDING;
  logic [1:0] WORD_LEN, STOP_HALVES;
  logic [3:0] DATA_BITS;
  logic [15:0] DIVISOR;
  logic [4:0] trig [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
  logic [7:0] code [4] = '{8'h04, 8'h02, 8'h06, 8'h00};
  int n_mismatch = 0;
  int samples_checked = 0;
  always #12.5 CORE_CLK = ~CORE_CLK;
  uart_irq_fifo_line_ctrl i_uart_irq_fifo_line_ctrl (.CORE_CLK(CORE_CLK), .NRST(NRST),
    .CLK_EN(CLK_EN), .ADDR(ADDR), .WR_STB(WR_STB), .RD_STB(RD_STB), .WDATA(WDATA),
    .RDATA(RDATA), .LINE_ERR_IN(LINE_ERR_IN), .RX_LEVEL_MET(RX_LEVEL_MET),
    .RX_COUNT(RX_COUNT), .RX_TIMEOUT_IN(RX_TIMEOUT_IN), .TX_EMPTY_IN(TX_EMPTY_IN),
    .MODEM_CHANGE_IN(MODEM_CHANGE_IN), .FIFO_ENABLE(FIFO_ENABLE), .RX_FLUSH(RX_FLUSH),
    .TX_FLUSH(TX_FLUSH), .RX_TRIGGER(RX_TRIGGER), .WORD_LEN(WORD_LEN),
    .DATA_BITS(DATA_BITS), .STOP_HALVES(STOP_HALVES), .STOP_CHECK_ONE(),
    .DIVISOR_ACCESS(DIVISOR_ACCESS), .DIVISOR(DIVISOR), .IRQ_PENDING(IRQ_PENDING));
  datapath_model i_datapath_model (.clk(CORE_CLK), .rx_flush(RX_FLUSH), .tx_flush(TX_FLUSH),
    .trigger(RX_TRIGGER), .line_err(LINE_ERR_IN), .rx_level(RX_LEVEL_MET),
    .rx_bytes(RX_COUNT), .rx_timeout(RX_TIMEOUT_IN), .tx_empty(TX_EMPTY_IN),
    .modem_change(MODEM_CHANGE_IN));
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    ADDR <= a;
    WDATA <= d;
    WR_STB <= 1'b1;
    @(posedge CORE_CLK);
    WR_STB <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge CORE_CLK);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge CORE_CLK);
    RD_STB <= 1'b0;
    #1;
    d = RDATA;
  endtask : rd
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task automatic t_reset;
    logic [7:0] v;
    check("data bits", 16'h5, DATA_BITS);
    check("trigger", 16'h1, RX_TRIGGER);
    rd(3'h2, v);
    check("ident", 16'h01, v);
    $display("reset test done");
  endtask : t_reset
  task automatic t_line;
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      wr(3'h3, i[7:0]);
      check("data bits", 4'h5 + 4'(i % 4), DATA_BITS);
      check("stop", i < 4 ? 2'h2 : (i == 4 ? 2'h3 : 2'h0), STOP_HALVES);
    end
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h34);
    wr(3'h1, 8'h12);
    check("divisor", 16'h1234, DIVISOR);
    wr(3'h3, 8'h00);
    wr(3'h1, 8'hFF);
    rd(3'h1, v);
    check("enable", 16'h0F, v);
    wr(3'h1, 8'h00);
    $display("line test done");
  endtask : t_line
  task automatic t_freeze;
    // a write while the clock enable is low must leave the format alone
    @(posedge CORE_CLK);
    CLK_EN <= 1'b0;
    wr(3'h3, 8'h03);
    check("frozen data bits", 16'h5, DATA_BITS);
    @(posedge CORE_CLK);
    CLK_EN <= 1'b1;
    $display("freeze test done");
  endtask : t_freeze
  task automatic t_fifo;
    logic [7:0] v;
    for (int t = 0; t < 4; t++) begin
      wr(3'h2, {t[1:0], 6'h01});
      check("trigger", trig[t], RX_TRIGGER);
      rd(3'h2, v);
      check("ident fifo", 16'hC1, v);
    end
    wr(3'h2, 8'h03);
    check("rx flush", 16'h1, RX_FLUSH);
    @(posedge CORE_CLK);
    #1;
    check("rx flush end", 16'h0, RX_FLUSH);
    wr(3'h2, 8'h05);
    check("tx flush", 16'h1, TX_FLUSH);
    wr(3'h2, 8'h09);
    check("bit3 flush", 16'h0, {RX_FLUSH, TX_FLUSH});
    wr(3'h2, 8'h00);
    check("fifo off", 16'h0, FIFO_ENABLE);
    rd(3'h2, v);
    check("ident off", 16'h01, v);
    $display("fifo test done");
  endtask : t_fifo
  task automatic t_irq;
    logic [7:0] v;
    // one enable bit at a time, then all four together; every source but the timeout is raised, only one may show
    for (int k = 0; k < 5; k++) begin
      wr(3'h1, k < 4 ? 8'h01 << k : 8'h0F);
      i_datapath_model.set_tx(1'b0);
      i_datapath_model.set_tx(1'b1);
      i_datapath_model.set_rx(5'h0E, 1'b0);
      i_datapath_model.pulse_modem;
      i_datapath_model.pulse_err(k % 4);
      repeat (2) @(posedge CORE_CLK);
      #1;
      check("pending", 16'h1, IRQ_PENDING);
      rd(3'h2, v);
      check("ident", k < 4 ? code[k] : 8'h06, v);
      rd(3'h5, v);
      rd(3'h2, v);
      check("after ls read", k == 1 || k == 2 ? 8'h01 : (k == 4 ? 8'h04 : code[k]), v);
      i_datapath_model.set_rx(5'h00, 1'b0);
      repeat (2) @(posedge CORE_CLK);
      rd(3'h2, v);
      check("after rx drop", k == 4 ? 8'h02 : (k == 3 ? 8'h00 : 8'h01), v);
      wr(3'h0, 8'h55);
      rd(3'h6, v);
      rd(3'h2, v);
      check("cleared", 16'h01, v);
      check("no pending", 16'h0, IRQ_PENDING);
    end
    // transmit empty raised again and cleared by a buffer write alone
    wr(3'h1, 8'h02);
    i_datapath_model.set_tx(1'b0);
    i_datapath_model.set_tx(1'b1);
    repeat (2) @(posedge CORE_CLK);
    #1;
    check("tx pending", 16'h1, IRQ_PENDING);
    wr(3'h0, 8'h55);
    rd(3'h2, v);
    check("tx write clear", 16'h01, v);
    wr(3'h1, 8'h00);
    $display("interrupt test done");
  endtask : t_irq
  task automatic t_timeout;
    logic [7:0] v;
    wr(3'h2, 8'hC1);
    wr(3'h1, 8'h01);
    i_datapath_model.set_rx(5'h01, 1'b1);
    repeat (2) @(posedge CORE_CLK);
    rd(3'h2, v);
    check("timeout", 16'hCC, v);
    wr(3'h2, 8'h00);
    repeat (2) @(posedge CORE_CLK);
    rd(3'h2, v);
    check("timeout gone", 16'h01, v);
    $display("timeout test done");
  endtask : t_timeout
  initial begin
    repeat (8) @(posedge CORE_CLK);
    NRST <= 1'b1;
    t_reset;
    t_line;
    t_freeze;
    t_fifo;
    t_irq;
    t_timeout;
    report_and_stop;
  end
  initial begin
    repeat (20000) @(posedge CORE_CLK);
    n_mismatch++;
    report_and_stop;
  end
endmodule : uart_irq_fifo_line_ctrl_tb_top
